// ### shared/bbe_pkg.sv
// Purpose: Constants and types for the bit and block error checker
// Assumes: The device under test returns bit clock, data and data enable
// Notes: Rates are reported as checked and error counts
// How it works
// - Lock onto the returned pseudo-random stream, then count disagreeing bits.
// - Bit error rate is erroneous bits over all checked bits.
// - Block mode compares computed and received checksum; a difference is a block error.
// - Block error rate is faulty blocks over evaluated blocks.
// - At start, fill the sequence register from input bits, then switch to feedback.
// - In feedback, compare each bit with the local bit; count mismatches.
// - Analysis may start anywhere in the stream; no alignment needed.
// - Checksum register is cleared to zero at each block start.
// - Every payload bit passes the checksum register before comparison.
// - Received checksum goes to its own register, compared as one 16-bit word after its last bit.
// - Checksum polynomial has terms at powers 16, 12, 5 and 0.
// - Show clock activity, data activity and sequence lock.
// - Local sequence repeats with period set by the chosen polynomial.
// - Bits with data enable low are not counted.
// - Checked and error counters are 32 bits wide.
// - Stop at checked or error limit and record which one stopped it.
package bbe_pkg;
  // ***********************
  // Sizes and constants
  // ***********************
  localparam int CRC_W = 16;
  localparam logic [4:0] CRC_LAST = 5'h0F;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [4:0] P9_LEN = 5'h09;
  localparam logic [4:0] P9_TAP = 5'h05;
  localparam logic [4:0] P15_LEN = 5'h0F;
  localparam logic [4:0] P15_TAP = 5'h0E;
  localparam logic [4:0] P23_LEN = 5'h17;
  localparam logic [4:0] P23_TAP = 5'h12;
  localparam int ACT_TIME_NS = 10000;
  localparam int SYS_PERIOD_NS = 100;
  localparam int ACT_CYC = (ACT_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [7:0] ACT_CNT = 8'(ACT_CYC);
  localparam logic [31:0] CNT_ONE = 32'h0000_0001;
  localparam logic [31:0] CNT_ZERO = 32'h0000_0000;

  // ***********************
  // Types
  // ***********************
  typedef enum logic [1:0] {BBE_IDLE, BBE_FILL, BBE_RUN, BBE_DONE} bbe_st_t;
  typedef enum logic [1:0] {BBE_P9, BBE_P15, BBE_P23} bbe_poly_t;

  typedef struct packed {
    logic block_mode;
    bbe_poly_t poly;
    logic [31:0] max_checked;
    logic [31:0] max_errors;
  } bbe_cfg_t;

  typedef struct packed {
    logic [31:0] checked;
    logic [31:0] errors;
    logic sync;
    logic done;
    logic stop_cnt;
    logic stop_err;
    logic block_mode;
  } bbe_res_t;

  typedef struct packed {
    logic data_s1;
    logic data_s2;
    logic den_s1;
    logic den_s2;
    logic den_d;
    logic start_s1;
    logic start_s2;
    logic start_s3;
    logic ack_s1;
    logic ack_s2;
    logic alive;
    logic sync;
    logic stop_cnt;
    logic stop_err;
    logic req;
    logic dirty;
    logic cap;
    bbe_st_t st;
    logic [22:0] prbs;
    logic [4:0] fill_cnt;
    logic [4:0] crc_cnt;
    logic [15:0] crc;
    logic [15:0] rx_crc;
    logic [31:0] checked;
    logic [31:0] errors;
    bbe_res_t rep;
  } bbe_lnk_t;

  typedef struct packed {
    logic start_tgl;
    logic ack;
    logic req_s1;
    logic req_s2;
    logic alive_s1;
    logic alive_s2;
    logic alive_d;
    logic dat_s1;
    logic dat_s2;
    logic dat_d;
    logic sync_s1;
    logic sync_s2;
    logic clk_act;
    logic dat_act;
    logic head_v;
    logic tail_v;
    logic [7:0] clk_tmr;
    logic [7:0] dat_tmr;
    bbe_cfg_t cfg;
    bbe_res_t head;
    bbe_res_t tail;
  } bbe_sys_t;

  // ***********************
  // Functions
  // ***********************
  function automatic logic [15:0] bbe_crc_step(input logic [15:0] crc, input logic b);
    logic fb;
    fb = crc[15] ^ b;
    bbe_crc_step = {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
  endfunction

  function automatic logic [4:0] bbe_len(input bbe_poly_t p);
    unique case (p)
      BBE_P9: bbe_len = P9_LEN;
      BBE_P15: bbe_len = P15_LEN;
      default: bbe_len = P23_LEN;
    endcase
  endfunction

  function automatic logic bbe_prbs_exp(input logic [22:0] r, input bbe_poly_t p);
    logic [4:0] tap;
    unique case (p)
      BBE_P9: tap = P9_TAP;
      BBE_P15: tap = P15_TAP;
      default: tap = P23_TAP;
    endcase
    bbe_prbs_exp = r[bbe_len(p) - 5'h01] ^ r[tap - 5'h01];
  endfunction
endpackage

// ### logic/bbe_checker.sv
// Purpose: Bit and block error checker on a returned serial stream
// Assumes: i_link_clk is the returned bit clock; data sampled on its rise
// Notes: Results cross by toggle handshake into a two-entry buffer
`timescale 1ns/1ps
`default_nettype none
module bbe_checker (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_link_clk,
  input wire logic i_link_data,
  input wire logic i_link_den,
  input wire logic i_start,
  input wire bbe_pkg::bbe_cfg_t i_cfg,
  input wire logic i_res_ready,
  output logic o_res_valid,
  output bbe_pkg::bbe_res_t o_res,
  output logic o_clk_active,
  output logic o_data_active,
  output logic o_sync
);
  bbe_pkg::bbe_lnk_t l_reg;
  bbe_pkg::bbe_lnk_t l_next;
  bbe_pkg::bbe_sys_t s_reg;
  bbe_pkg::bbe_sys_t s_next;
  logic w_bit;
  logic w_en;
  logic w_rise;
  logic w_fall;
  logic w_start;
  logic w_exp;
  logic w_cmp;
  logic w_blk;
  logic [4:0] w_len;
  logic [15:0] w_rxn;
  logic w_push;
  logic w_pop;

  function automatic logic [7:0] act_tmr(input logic chg, input logic [7:0] t);
    if (chg) begin
      act_tmr = bbe_pkg::ACT_CNT;
    end else if (t != 8'h00) begin
      act_tmr = t - 8'h01;
    end else begin
      act_tmr = 8'h00;
    end
  endfunction

  // ***********************
  // Link side decode
  // ***********************
  assign w_bit = l_reg.data_s2;
  assign w_en = l_reg.den_s2;
  assign w_rise = w_en & ~l_reg.den_d;
  assign w_fall = ~w_en & l_reg.den_d;
  assign w_start = l_reg.start_s2 ^ l_reg.start_s3;
  assign w_blk = s_reg.cfg.block_mode;
  assign w_len = bbe_pkg::bbe_len(s_reg.cfg.poly);
  assign w_exp = bbe_pkg::bbe_prbs_exp(l_reg.prbs, s_reg.cfg.poly);
  assign w_rxn = {l_reg.rx_crc[14:0], w_bit};
  assign w_cmp = ~w_en & (w_fall | l_reg.cap) & (l_reg.crc_cnt == bbe_pkg::CRC_LAST);

  // ***********************
  // Link side state
  // ***********************
  always_comb begin
    l_next = l_reg;
    l_next.data_s1 = i_link_data;
    l_next.data_s2 = l_reg.data_s1;
    l_next.den_s1 = i_link_den;
    l_next.den_s2 = l_reg.den_s1;
    l_next.den_d = w_en;
    l_next.start_s1 = s_reg.start_tgl;
    l_next.start_s2 = l_reg.start_s1;
    l_next.start_s3 = l_reg.start_s2;
    l_next.ack_s1 = s_reg.ack;
    l_next.ack_s2 = l_reg.ack_s1;
    l_next.alive = ~l_reg.alive;
    if (w_start) begin
      // Begin anywhere in the stream
      l_next.st = w_blk ? bbe_pkg::BBE_RUN : bbe_pkg::BBE_FILL;
      l_next.sync = w_blk;
      l_next.fill_cnt = 5'h00;
      l_next.crc_cnt = 5'h00;
      l_next.cap = 1'b0;
      l_next.checked = bbe_pkg::CNT_ZERO;
      l_next.errors = bbe_pkg::CNT_ZERO;
      l_next.stop_cnt = 1'b0;
      l_next.stop_err = 1'b0;
      l_next.dirty = 1'b1;
    end else begin
      unique case (l_reg.st)
        bbe_pkg::BBE_IDLE: begin
        end
        bbe_pkg::BBE_DONE: begin
        end
        bbe_pkg::BBE_FILL: begin
          if (w_en) begin
            // Load straight from the line
            l_next.prbs = {l_reg.prbs[21:0], w_bit};
            l_next.fill_cnt = l_reg.fill_cnt + 5'h01;
            if (l_next.fill_cnt == w_len) begin
              l_next.st = bbe_pkg::BBE_RUN;
              l_next.sync = 1'b1;
              l_next.dirty = 1'b1;
            end
          end
        end
        bbe_pkg::BBE_RUN: begin
          if (!w_blk) begin
            if (w_en) begin
              l_next.prbs = {l_reg.prbs[21:0], w_exp};
              l_next.checked = l_reg.checked + bbe_pkg::CNT_ONE;
              if (w_bit != w_exp) begin
                l_next.errors = l_reg.errors + bbe_pkg::CNT_ONE;
              end
              l_next.dirty = 1'b1;
            end
          end else begin
            if (w_en) begin
              // Clear at block start, then shift payload
              l_next.crc = bbe_pkg::bbe_crc_step(w_rise ? bbe_pkg::CRC_INIT : l_reg.crc,
                w_bit);
            end else if (w_fall | l_reg.cap) begin
              l_next.rx_crc = w_rxn;
              l_next.crc_cnt = l_reg.crc_cnt + 5'h01;
              l_next.cap = 1'b1;
              if (w_cmp) begin
                l_next.cap = 1'b0;
                l_next.crc_cnt = 5'h00;
                l_next.checked = l_reg.checked + bbe_pkg::CNT_ONE;
                if (w_rxn != l_reg.crc) begin
                  l_next.errors = l_reg.errors + bbe_pkg::CNT_ONE;
                end
                l_next.dirty = 1'b1;
              end
            end
          end
          // Limits end the run
          if (s_reg.cfg.max_checked != bbe_pkg::CNT_ZERO &&
              l_next.checked == s_reg.cfg.max_checked) begin
            l_next.stop_cnt = 1'b1;
          end
          if (s_reg.cfg.max_errors != bbe_pkg::CNT_ZERO &&
              l_next.errors == s_reg.cfg.max_errors) begin
            l_next.stop_err = 1'b1;
          end
          if (l_next.stop_cnt | l_next.stop_err) begin
            l_next.st = bbe_pkg::BBE_DONE;
            l_next.dirty = 1'b1;
          end
        end
      endcase
    end
    // Snapshot results when the last one is taken
    if (l_next.dirty && l_reg.req == l_reg.ack_s2) begin
      l_next.rep.checked = l_next.checked;
      l_next.rep.errors = l_next.errors;
      l_next.rep.sync = l_next.sync;
      l_next.rep.done = (l_next.st == bbe_pkg::BBE_DONE);
      l_next.rep.stop_cnt = l_next.stop_cnt;
      l_next.rep.stop_err = l_next.stop_err;
      l_next.rep.block_mode = w_blk;
      l_next.req = ~l_reg.req;
      l_next.dirty = 1'b0;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  // ***********************
  // System side
  // ***********************
  assign w_pop = s_reg.head_v & i_res_ready;
  assign w_push = (s_reg.req_s2 != s_reg.ack) & ~(s_reg.head_v & s_reg.tail_v);

  always_comb begin
    s_next = s_reg;
    s_next.req_s1 = l_reg.req;
    s_next.req_s2 = s_reg.req_s1;
    s_next.alive_s1 = l_reg.alive;
    s_next.alive_s2 = s_reg.alive_s1;
    s_next.alive_d = s_reg.alive_s2;
    s_next.dat_s1 = i_link_data;
    s_next.dat_s2 = s_reg.dat_s1;
    s_next.dat_d = s_reg.dat_s2;
    s_next.sync_s1 = l_reg.sync;
    s_next.sync_s2 = s_reg.sync_s1;
    if (i_start) begin
      s_next.start_tgl = ~s_reg.start_tgl;
      s_next.cfg = i_cfg;
    end
    s_next.clk_tmr = act_tmr(s_reg.alive_s2 != s_reg.alive_d, s_reg.clk_tmr);
    s_next.dat_tmr = act_tmr(s_reg.dat_s2 != s_reg.dat_d, s_reg.dat_tmr);
    s_next.clk_act = (s_next.clk_tmr != 8'h00);
    s_next.dat_act = (s_next.dat_tmr != 8'h00);
    // Two-entry result buffer
    s_next.head_v = s_reg.head_v & ~w_pop;
    if (!s_next.head_v && s_reg.tail_v) begin
      s_next.head = s_reg.tail;
      s_next.head_v = 1'b1;
      s_next.tail_v = 1'b0;
    end
    if (w_push) begin
      s_next.ack = s_reg.req_s2;
      if (!s_next.head_v) begin
        s_next.head = l_reg.rep;
        s_next.head_v = 1'b1;
      end else begin
        s_next.tail = l_reg.rep;
        s_next.tail_v = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_res_valid = s_reg.head_v;
  assign o_res = s_reg.head;
  assign o_clk_active = s_reg.clk_act;
  assign o_data_active = s_reg.dat_act;
  assign o_sync = s_reg.sync_s2;

  // ***********************
  // Checks
  // ***********************
  sequence fill_done_s;
    l_reg.st == bbe_pkg::BBE_FILL && w_en && !w_start &&
      l_reg.fill_cnt == w_len - 5'h01;
  endsequence

  sequence blk_mis_s;
    l_reg.st == bbe_pkg::BBE_RUN && w_blk && w_cmp && !w_start && w_rxn != l_reg.crc;
  endsequence

  sequence stall_s;
    o_res_valid && !i_res_ready;
  endsequence

  fill_switch_a: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
    fill_done_s |=> l_reg.st == bbe_pkg::BBE_RUN && l_reg.sync)
    else $error("Fill did not switch to feedback");

  fill_hold_a: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
    (l_reg.st == bbe_pkg::BBE_FILL && !w_start && !w_en) |=>
      l_reg.st == bbe_pkg::BBE_FILL && $stable(l_reg.fill_cnt))
    else $error("Fill advanced without enabled bit");

  bit_error_a: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
    (l_reg.st == bbe_pkg::BBE_RUN && !w_blk && w_en && !w_start && w_bit != w_exp) |=>
      l_reg.errors == $past(l_reg.errors) + bbe_pkg::CNT_ONE)
    else $error("Mismatch not counted");

  den_gate_a: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
    (l_reg.st == bbe_pkg::BBE_RUN && !w_blk && !w_en && !w_start) |=>
      $stable(l_reg.checked) && $stable(l_reg.prbs))
    else $error("Masked bit was checked");

  crc_clear_a: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
    (l_reg.st == bbe_pkg::BBE_RUN && w_blk && w_rise && !w_start) |=>
      l_reg.crc == bbe_pkg::bbe_crc_step(bbe_pkg::CRC_INIT, $past(w_bit)))
    else $error("Checksum not restarted at block");

  blk_error_a: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
    blk_mis_s |=> l_reg.errors == $past(l_reg.errors) + bbe_pkg::CNT_ONE &&
      l_reg.checked == $past(l_reg.checked) + bbe_pkg::CNT_ONE)
    else $error("Block error not counted");

  limit_stop_a: assert property (@(posedge i_link_clk) disable iff (!i_resetn)
    $rose(l_reg.stop_cnt) |-> l_reg.checked == s_reg.cfg.max_checked &&
      l_reg.st == bbe_pkg::BBE_DONE)
    else $error("Count limit stop wrong");

  clk_seen_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (s_reg.alive_s2 != s_reg.alive_d) |=> o_clk_active [*2])
    else $error("Clock activity not shown");

  stall_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    stall_s |=> o_res_valid && $stable(o_res))
    else $error("Result lost under stall");
endmodule
`default_nettype wire

// ### verif/bbe_dut_model.sv
// Purpose: Behavioural model of the unit under test returning clock, data and enable
// Assumes: Bit clock period 6 ns, runs only within frames
// Notes: Idle bits carry an inverted, ever-changing level with enable low
`timescale 1ns/1ps
`default_nettype none
module bbe_dut_model (
  output logic o_link_clk,
  output logic o_link_data,
  output logic o_link_den
);
  // ***********************
  // State
  // ***********************
  logic [22:0] lfsr_reg = 23'h7_A5F3;
  logic [15:0] crc_reg = 16'h0000;
  initial begin
    o_link_clk = 1'b0;
    o_link_data = 1'b0;
    o_link_den = 1'b0;
  end
  // ***********************
  // Bit and frame tasks
  // ***********************
  task automatic tick(input logic d, input logic e);
    o_link_data = d;
    o_link_den = e;
    #3 o_link_clk = 1'b1;
    #3 o_link_clk = 1'b0;
  endtask
  task automatic frame(input int len, input int tap, input int n, input int errn,
                       input logic gaps, input logic blk, input logic bad);
    logic b;
    logic t;
    crc_reg = 16'h0000;
    repeat (8) tick(~o_link_data, 1'b0);
    for (int i = 0; i < n; i++) begin
      b = lfsr_reg[len-1] ^ lfsr_reg[tap-1];
      lfsr_reg = {lfsr_reg[21:0], b};
      crc_reg = {crc_reg[14:0], 1'b0} ^ ((crc_reg[15] ^ b) ? 16'h1021 : 16'h0000);
      t = b ^ (i >= 40 && (i - 40) % 7 == 0 && (i - 40) / 7 < errn);
      if (gaps && i % 8 == 4) tick(~b, 1'b0);
      tick(t, 1'b1);
    end
    if (blk) begin
      for (int k = 15; k >= 0; k--) tick(crc_reg[k] ^ (bad && k == 0), 1'b0);
    end
    repeat (1500) tick(~o_link_data, 1'b0);
  endtask
endmodule
`default_nettype wire

// ### verif/bbe_checker_tb.sv
// Purpose: Self-checking bench for the bit and block error checker
// Assumes: Result sink normally ready; model link clock stands still between frames
// Notes: Table rows for measurements, then buffer stall and idle activity tests
`timescale 1ns/1ps
`default_nettype none
module bbe_checker_tb;
  // ***********************
  // Signals
  // ***********************
  typedef struct {
    bbe_pkg::bbe_poly_t poly;
    logic blk;
    int n;
    int errn;
    logic gaps;
    logic bad;
    logic [7:0] maxc;
    logic [7:0] maxe;
    logic [7:0] chk;
    logic [7:0] err;
    logic sc;
    logic se;
  } bbe_row_t;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b1;
  logic i_start = 1'b0;
  bbe_pkg::bbe_cfg_t i_cfg = '0;
  logic i_res_ready = 1'b1;
  logic link_clk;
  logic link_data;
  logic link_den;
  logic o_res_valid;
  logic o_clk_active;
  logic o_data_active;
  logic o_sync;
  bbe_pkg::bbe_res_t o_res;
  bbe_pkg::bbe_res_t last_res = '0;
  bbe_pkg::bbe_res_t held_res;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  bbe_row_t rows [7] = '{
    '{bbe_pkg::BBE_P9, 1'b0, 60, 0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h33, 8'h00, 1'b0, 1'b0},
    '{bbe_pkg::BBE_P15, 1'b0, 80, 2, 1'b1, 1'b0, 8'h00, 8'h00, 8'h41, 8'h02, 1'b0, 1'b0},
    '{bbe_pkg::BBE_P23, 1'b0, 60, 1, 1'b0, 1'b0, 8'h00, 8'h00, 8'h25, 8'h01, 1'b0, 1'b0},
    '{bbe_pkg::BBE_P9, 1'b0, 60, 0, 1'b0, 1'b0, 8'h14, 8'h00, 8'h14, 8'h00, 1'b1, 1'b0},
    '{bbe_pkg::BBE_P15, 1'b0, 80, 3, 1'b0, 1'b0, 8'h00, 8'h02, 8'h21, 8'h02, 1'b0, 1'b1},
    '{bbe_pkg::BBE_P9, 1'b1, 32, 0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h01, 8'h00, 1'b0, 1'b0},
    '{bbe_pkg::BBE_P9, 1'b1, 32, 0, 1'b0, 1'b1, 8'h00, 8'h00, 8'h01, 8'h01, 1'b0, 1'b0}
  };
  // ***********************
  // Design, model, clock
  // ***********************
  bbe_checker dut (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_link_clk(link_clk),
    .i_link_data(link_data),
    .i_link_den(link_den),
    .i_start(i_start),
    .i_cfg(i_cfg),
    .i_res_ready(i_res_ready),
    .o_res_valid(o_res_valid),
    .o_res(o_res),
    .o_clk_active(o_clk_active),
    .o_data_active(o_data_active),
    .o_sync(o_sync)
  );
  bbe_dut_model model (
    .o_link_clk(link_clk),
    .o_link_data(link_data),
    .o_link_den(link_den)
  );
  always #50 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    if (o_res_valid === 1'b1 && i_res_ready === 1'b1) last_res <= o_res;
  end
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // ***********************
  // Tasks
  // ***********************
  task automatic report_and_stop();
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic start_run(input bbe_row_t r);
    @(posedge i_sys_clk);
    i_cfg <= '{block_mode: r.blk, poly: r.poly, max_checked: 32'(r.maxc),
               max_errors: 32'(r.maxe)};
    i_start <= 1'b1;
    @(posedge i_sys_clk);
    i_start <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
  endtask
  task automatic run_row(input bbe_row_t r);
    int len;
    int tap;
    len = (r.poly == bbe_pkg::BBE_P9) ? 9 : (r.poly == bbe_pkg::BBE_P15) ? 15 : 23;
    tap = (r.poly == bbe_pkg::BBE_P9) ? 5 : (r.poly == bbe_pkg::BBE_P15) ? 14 : 18;
    start_run(r);
    model.frame(len, tap, r.n, r.errn, r.gaps, r.blk, r.bad);
    @(negedge i_sys_clk);
    check("checked", 32'(r.chk), last_res.checked);
    check("errors", 32'(r.err), last_res.errors);
    check("flags", {27'h000_0000, r.blk, r.sc | r.se, r.sc, r.se, 1'b1},
          {27'h000_0000, last_res.block_mode, last_res.done, last_res.stop_cnt,
           last_res.stop_err, last_res.sync});
    check("status", 32'h0000_0007, {29'h0000_0000, o_clk_active, o_data_active, o_sync});
  endtask
  // ***********************
  // Main sequence
  // ***********************
  initial begin
    // Falling reset edge clears the link side while its clock stands still
    @(posedge i_sys_clk);
    i_resetn <= 1'b0;
    repeat (20) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    check("reset", 32'h0000_0000, {28'h000_0000, o_res_valid, o_clk_active,
          o_data_active, o_sync});
    @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    for (int i = 0; i < 7; i++) run_row(rows[i]);
    i_res_ready <= 1'b0;
    start_run(rows[0]);
    fork
      model.frame(9, 5, 60, 0, 1'b0, 1'b0, 1'b0);
      begin
        repeat (40) @(negedge i_sys_clk);
        check("held_valid", 32'h0000_0001, {31'h0000_0000, o_res_valid});
        held_res = o_res;
        repeat (4) @(negedge i_sys_clk);
        check("held_res", held_res.checked, o_res.checked);
        @(posedge i_sys_clk);
        i_res_ready <= 1'b1;
      end
    join
    @(negedge i_sys_clk);
    check("drained", 32'h0000_0033, last_res.checked);
    repeat (150) @(negedge i_sys_clk);
    check("idle", 32'h0000_0000, {30'h0000_0000, o_clk_active, o_data_active});
    report_and_stop();
  end
endmodule
`default_nettype wire
